// file: core/soc_pkg.sv
// Purpose: Shared constants for the system option configuration block
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   Option bits sit in the low byte of the option register
package soc_pkg;
   localparam int          ADDR_W       = 4;
   localparam int          DATA_W       = 32;
   localparam int          CNT_W        = 13;
   // Register byte offsets
   localparam logic [3:0]  OPT_OFS      = 4'h0;
   localparam logic [3:0]  STAT_OFS     = 4'h4;
   // Option register field positions
   localparam int          EXT_CLK_BIT  = 0;
   localparam int          EXT_XTAL_BIT = 1;
   localparam int          SLOW_BIT     = 2;
   localparam int          VM_OFF_BIT   = 3;
   localparam int          VM_RANGE_BIT = 4;
   localparam int          SHORT_BIT    = 5;
   localparam int          STOP_EN_BIT  = 6;
   localparam int          WDOG_OFF_BIT = 7;
   localparam int          OPT_W        = 8;
   localparam int          SEL_LOW      = 0;
   // Status register field positions
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_LONG_BIT  = 1;
   localparam int          ST_CNT_LSB   = 16;
   // Reset values
   localparam logic [7:0]  OPT_RST      = 8'h00;
   localparam logic        RANGE_RST    = 1'h0;
   // Recovery delays in oscillator reference clock cycles
   localparam logic [12:0] SHORT_DELAY  = 13'h0020;
   localparam logic [12:0] LONG_DELAY   = 13'h1000;
   localparam logic [12:0] CNT_ZERO     = 13'h0000;
   localparam logic [12:0] CNT_ONE      = 13'h0001;
   localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

   typedef enum logic {
      REC_IDLE,
      REC_COUNT
   } soc_rec_e;
endpackage

// file: core/soc_top.sv
// Purpose: System option configuration bits and their decoded controls
// Assumes: Single 40 MHz clock, synchronous active-low resets, tick input
//          marks one oscillator reference clock cycle
// Notes:   Option register and status register reached over Wishbone
//
// Function
// - Clock enable turns first pin clock
// - Clock enable off keeps both pins port
// - Clock only: square wave, second pin port
// - Clock and crystal: both pins crystal
// - Slow option selects slow crystal range
// - Slow option sets monitor frequency expectation
// - Power-off option unpowers voltage monitor
// - Range option picks 5 V or 3 V
// - Range bit cleared by power-on only
// - Short option gives 32, else 4096 cycles
// - Voltage-monitor reset exit always long delay
// - Power-on waits 4096 reference cycles
// - Stop disabled means stop opcode illegal
// - Watchdog disable option holds watchdog off
//
// Our own choices: register access over Wishbone and the placing of the registers.
module soc_top
   import soc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    porN,
   input  wire logic                    wbCyc,
   input  wire logic                    wbStb,
   input  wire logic                    wbWe,
   input  wire logic [soc_pkg::ADDR_W-1:0] wbAdr,
   input  wire logic [3:0]              wbSel,
   input  wire logic [soc_pkg::DATA_W-1:0] wbDatI,
   output logic      [soc_pkg::DATA_W-1:0] wbDatO,
   output logic                         wbAck,
   input  wire logic                    oscRefTick,
   input  wire logic                    stopExitReq,
   input  wire logic                    exitByLviReset,
   input  wire logic                    stopOpcode,
   output logic                         pin6ClockIn,
   output logic                         pin7CrystalOut,
   output logic                         extOscEnable,
   output logic                         slowCrystalSel,
   output logic                         clkMonExpectLow,
   output logic                         vmonPowerOff,
   output logic                         vmonRange5V,
   output logic                         stopExecute,
   output logic                         illegalOpcode,
   output logic                         watchdogDisable,
   output logic                         recoveryBusy
);
   import soc_pkg::*;

   logic [OPT_W-1:0] optReg;
   logic             rangeReg;
   soc_rec_e         recState_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             longUsed_reg;
   logic             wbReq;
   logic             optWr;
   logic             recStart;
   logic             useLong;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wbReq    = wbCyc && wbStb && !wbAck;
   assign optWr    = wbReq && wbWe && hit(wbAdr, OPT_OFS) && wbSel[SEL_LOW];
   assign recStart = stopExitReq && (recState_reg == REC_IDLE);
   assign useLong  = exitByLviReset || !optReg[SHORT_BIT];

   // Bus acknowledge, one cycle after request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wbAck <= 1'b0;
      end else begin
         wbAck <= wbReq;
      end
   end

   // Read data mux, unmapped reads return zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wbDatO <= DATA_ZERO;
      end else if (wbReq && !wbWe) begin
         wbDatO <= DATA_ZERO;
         if (hit(wbAdr, OPT_OFS)) begin
            wbDatO[OPT_W-1:0]   <= optReg;
            wbDatO[VM_RANGE_BIT] <= rangeReg;
         end else if (hit(wbAdr, STAT_OFS)) begin
            wbDatO[ST_BUSY_BIT] <= (recState_reg == REC_COUNT);
            wbDatO[ST_LONG_BIT] <= longUsed_reg;
            wbDatO[ST_CNT_LSB +: CNT_W] <= cnt_reg;
         end
      end
   end

   // Option bits, cleared by any reset
   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         optReg <= OPT_RST;
      end else if (optWr) begin
         optReg <= wbDatI[OPT_W-1:0];
      end
   end

   // Range held across non power-on resets
   always_ff @(posedge clk) begin
      if (!porN) begin
         rangeReg <= RANGE_RST;
      end else if (nrst && optWr) begin
         rangeReg <= wbDatI[VM_RANGE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         pin6ClockIn <= 1'b0;
      end else begin
         pin6ClockIn <= optReg[EXT_CLK_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         pin7CrystalOut <= 1'b0;
      end else begin
         pin7CrystalOut <= optReg[EXT_CLK_BIT] && optReg[EXT_XTAL_BIT];
      end
   end

   // Square wave input on first pin
   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         extOscEnable <= 1'b0;
      end else begin
         extOscEnable <= optReg[EXT_CLK_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         slowCrystalSel  <= 1'b0;
         clkMonExpectLow <= 1'b0;
      end else begin
         slowCrystalSel  <= optReg[SLOW_BIT];
         clkMonExpectLow <= optReg[SLOW_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!porN) begin
         vmonPowerOff <= 1'b0;
         vmonRange5V  <= RANGE_RST;
      end else if (!nrst) begin
         vmonPowerOff <= 1'b0;
         vmonRange5V  <= rangeReg;
      end else begin
         vmonPowerOff <= optReg[VM_OFF_BIT];
         vmonRange5V  <= rangeReg;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         watchdogDisable <= 1'b0;
      end else begin
         watchdogDisable <= optReg[WDOG_OFF_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !porN) begin
         stopExecute   <= 1'b0;
         illegalOpcode <= 1'b0;
      end else begin
         stopExecute   <= stopOpcode && optReg[STOP_EN_BIT];
         illegalOpcode <= stopOpcode && !optReg[STOP_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!porN) begin
         recState_reg <= REC_COUNT;
         cnt_reg      <= LONG_DELAY;
         longUsed_reg <= 1'b1;
      end else if (!nrst) begin
         recState_reg <= REC_IDLE;
         cnt_reg      <= CNT_ZERO;
         longUsed_reg <= 1'b0;
      end else begin
         case (recState_reg)
            REC_IDLE: begin
               if (recStart) begin
                  recState_reg <= REC_COUNT;
                  cnt_reg      <= useLong ? LONG_DELAY : SHORT_DELAY;
                  longUsed_reg <= useLong;
               end
            end
            REC_COUNT: begin
               if (oscRefTick) begin
                  cnt_reg <= cnt_reg - CNT_ONE;
                  if (cnt_reg == CNT_ONE) begin
                     recState_reg <= REC_IDLE;
                  end
               end
            end
            default: begin
               recState_reg <= REC_IDLE;
            end
         endcase
      end
   end

   // Busy output mirrors the next recovery state
   always_ff @(posedge clk) begin
      if (!nrst && porN) begin
         recoveryBusy <= 1'b0;
      end else if (!porN) begin
         recoveryBusy <= 1'b1;
      end else begin
         case (recState_reg)
            REC_IDLE:  recoveryBusy <= recStart;
            REC_COUNT: recoveryBusy <= !(oscRefTick && cnt_reg == CNT_ONE);
            default:   recoveryBusy <= 1'b0;
         endcase
      end
   end

   a_pin_default: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      !optReg[EXT_CLK_BIT] |=> !pin6ClockIn && !extOscEnable)
      else $error("first pin left clock input with option clear");

   a_xtal_gated: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      !optReg[EXT_CLK_BIT] && optReg[EXT_XTAL_BIT]
      |=> !pin7CrystalOut && !extOscEnable)
      else $error("crystal pin active without clock enable");

   a_square_wave: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      optReg[EXT_CLK_BIT] && !optReg[EXT_XTAL_BIT]
      |=> pin6ClockIn && !pin7CrystalOut)
      else $error("square wave mode pin decode wrong");

   a_crystal_pair: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      optReg[EXT_CLK_BIT] && optReg[EXT_XTAL_BIT]
      |=> pin6ClockIn && pin7CrystalOut)
      else $error("crystal mode pin decode wrong");

   a_slow_sel: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      optReg[SLOW_BIT] |=> slowCrystalSel)
      else $error("slow crystal range not selected");

   a_slow_pair: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      slowCrystalSel == clkMonExpectLow)
      else $error("monitor expectation differs from crystal range");

   a_vm_power: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      optReg[VM_OFF_BIT] |=> vmonPowerOff)
      else $error("voltage monitor left powered");

   a_vm_range: assert property (
      @(posedge clk) disable iff (!porN)
      vmonRange5V == $past(rangeReg))
      else $error("trip range differs from range bit");

   a_range_keep: assert property (
      @(posedge clk) disable iff (!porN)
      !nrst |=> $stable(rangeReg))
      else $error("range bit changed on non power-on reset");

   a_short_rec: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      recStart && optReg[SHORT_BIT] && !exitByLviReset
      |=> cnt_reg == SHORT_DELAY && recoveryBusy)
      else $error("short recovery did not load 32");

   a_rec_end: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      recState_reg == REC_COUNT && oscRefTick && cnt_reg == CNT_ONE
      |=> !recoveryBusy && cnt_reg == CNT_ZERO)
      else $error("recovery did not end on its last tick");

   a_lvi_long: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      recStart && exitByLviReset |=> cnt_reg == LONG_DELAY && longUsed_reg)
      else $error("monitor reset exit did not use long delay");

   a_por_long: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(porN) |-> cnt_reg == LONG_DELAY && recoveryBusy)
      else $error("power-on did not load 4096 delay");

   a_stop_gate: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      stopOpcode && !optReg[STOP_EN_BIT] |=> illegalOpcode && !stopExecute)
      else $error("disabled stop opcode not flagged illegal");

   a_stop_run: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      stopOpcode && optReg[STOP_EN_BIT] |=> stopExecute && !illegalOpcode)
      else $error("enabled stop opcode did not execute");

   a_wdog_off: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      optReg[WDOG_OFF_BIT] ##1 optReg[WDOG_OFF_BIT] |-> watchdogDisable)
      else $error("watchdog not disabled");

   a_wdog_on: assert property (
      @(posedge clk) disable iff (!nrst || !porN)
      !optReg[WDOG_OFF_BIT] |=> !watchdogDisable)
      else $error("watchdog disabled with option clear");

   c_crystal: cover property (@(posedge clk) disable iff (!nrst || !porN)
      pin7CrystalOut);
   c_short_done: cover property (@(posedge clk) disable iff (!nrst || !porN)
      recStart && !useLong ##[1:200] !recoveryBusy);
   c_illegal: cover property (@(posedge clk) disable iff (!nrst || !porN)
      illegalOpcode);
   c_lvi_exit: cover property (@(posedge clk) disable iff (!nrst || !porN)
      recStart && exitByLviReset);
   c_range_kept: cover property (@(posedge clk) disable iff (!porN)
      !nrst && rangeReg);
endmodule

// file: dv/soc_far_model.sv
// Purpose: Far side model: reference clock ticks and CPU stop events
// Assumes: Same clock as the option block, bench commands the events
// Notes:   TICK_DIV bus clocks make one reference clock tick
module soc_far_model #(
   parameter int TICK_DIV = 2
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic reqExit,
   input  wire logic reqLvi,
   input  wire logic reqOp,
   output logic      oscRefTick,
   output logic      stopExitReq,
   output logic      exitByLviReset,
   output logic      stopOpcode
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] divCnt;

   always_ff @(posedge clk) begin
      if (!nrst || divCnt == 8'(TICK_DIV - 1)) begin
         divCnt <= 8'h00;
      end else begin
         divCnt <= divCnt + 8'h01;
      end
      oscRefTick <= nrst && divCnt == 8'(TICK_DIV - 1);
   end

   // Stop exit and opcode events
   always_ff @(posedge clk) begin
      stopExitReq    <= reqExit;
      exitByLviReset <= reqLvi;
      stopOpcode     <= reqOp;
   end
endmodule

// file: dv/soc_top_tb_top.sv
// Purpose: Self-checking bench for the option block
// Assumes: 40 MHz clock, reference tick every second clock
// Notes:   Option and status registers reached over classic Wishbone
module soc_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import soc_pkg::*;
   logic              clk = 1'b0, nrst = 1'b0, porN = 1'b0;
   logic              wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [ADDR_W-1:0] wbAdr = 4'h0;
   logic [3:0]        wbSel = 4'h0;
   logic [DATA_W-1:0] wbDatI = 32'h0, wbDatO, rd;
   logic              wbAck, reqExit = 1'b0, reqLvi = 1'b0, reqOp = 1'b0;
   logic              oscRefTick, stopExitReq, exitByLviReset, stopOpcode;
   logic              pin6ClockIn, pin7CrystalOut, extOscEnable;
   logic              slowCrystalSel, clkMonExpectLow, vmonPowerOff;
   logic              vmonRange5V, stopExecute, illegalOpcode;
   logic              watchdogDisable, recoveryBusy;
   logic [7:0]        v;
   int                failures = 0, comparisons = 0;

   always #12.5 clk = ~clk;

   soc_top DUT (.clk, .nrst, .porN, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
      .wbDatI, .wbDatO, .wbAck, .oscRefTick, .stopExitReq, .exitByLviReset,
      .stopOpcode, .pin6ClockIn, .pin7CrystalOut, .extOscEnable,
      .slowCrystalSel, .clkMonExpectLow, .vmonPowerOff, .vmonRange5V,
      .stopExecute, .illegalOpcode, .watchdogDisable, .recoveryBusy);

   soc_far_model #(.TICK_DIV(2)) FAR (.clk, .nrst(nrst && porN), .reqExit,
      .reqLvi, .reqOp, .oscRefTick, .stopExitReq, .exitByLviReset,
      .stopOpcode);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [3:0] adr,
                     input logic [3:0] sel, input logic [31:0] d);
      @(posedge clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbSel  <= sel;
      wbDatI <= d;
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      chk(wbAck, 1'b1);
   endtask

   task automatic setopt(input logic [7:0] val);
      wb(1'b1, OPT_OFS, 4'hF, {24'h0, val});
      @(posedge clk);
   endtask

   task automatic cnt_busy(output int n);
      logic seen;
      n = 0;
      seen = 1'b0;
      for (int k = 0; k < 20000; k++) begin
         @(posedge clk);
         if (recoveryBusy === 1'b1) begin
            seen = 1'b1;
            if (oscRefTick === 1'b1) n++;
         end else if (seen) break;
      end
   endtask

   task automatic rec(input logic low_voltage_monitor, input logic [12:0] expN);
      int n;
      reqLvi  <= low_voltage_monitor;
      reqExit <= 1'b1;
      @(posedge clk);
      reqExit <= 1'b0;
      cnt_busy(n);
      chk(n, expN);
      wb(1'b0, STAT_OFS, 4'hF, 32'h0);
      chk(rd & 32'h1FFF_0003, {30'h0, expN == LONG_DELAY, 1'b0});
      reqLvi <= 1'b0;
   endtask

   task automatic opchk(input logic en);
      logic ex, il;
      ex = 1'b0;
      il = 1'b0;
      reqOp <= 1'b1;
      @(posedge clk);
      reqOp <= 1'b0;
      repeat (4) begin
         @(posedge clk);
         ex |= stopExecute;
         il |= illegalOpcode;
      end
      chk({ex, il}, {en, ~en});
   endtask

   task automatic end_sim;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      end_sim;
   end

   initial begin
      int n;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      porN <= 1'b1;
      cnt_busy(n);
      chk(n, LONG_DELAY);
      for (int i = 0; i < 16; i++) begin
         v = 8'(i * 17);
         setopt(v);
         wb(1'b0, OPT_OFS, 4'hF, 32'h0);
         chk(rd, {24'h0, v});
         chk({pin6ClockIn, pin7CrystalOut, extOscEnable},
             {v[0], v[0] & v[1], v[0]});
         chk({slowCrystalSel, clkMonExpectLow, vmonPowerOff, vmonRange5V},
             {v[2], v[2], v[3], v[4]});
         chk(watchdogDisable, v[7]);
      end
      setopt(8'h00);
      wb(1'b1, OPT_OFS, 4'hE, 32'hFF);
      wb(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
      wb(1'b0, 4'hC, 4'hF, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, OPT_OFS, 4'hF, 32'h0);
      chk(rd, 32'h0);
      opchk(1'b0);
      setopt(8'h40);
      opchk(1'b1);
      setopt(8'h20);
      rec(1'b0, SHORT_DELAY);
      rec(1'b1, LONG_DELAY);
      setopt(8'h00);
      rec(1'b0, LONG_DELAY);
      setopt(8'hFF);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      wb(1'b0, OPT_OFS, 4'hF, 32'h0);
      chk(rd, 32'h10);
      chk({vmonRange5V, watchdogDisable}, 2'h2);
      porN <= 1'b0;
      repeat (2) @(posedge clk);
      porN <= 1'b1;
      cnt_busy(n);
      chk(n, LONG_DELAY);
      wb(1'b0, OPT_OFS, 4'hF, 32'h0);
      chk(rd, 32'h0);
      chk(vmonRange5V, 1'b0);
      end_sim;
   end
endmodule
